//--- sim/tb_adc_control_sequencer.sv
// Self-checking bench for the converter control sequencer register slave and handshake
`default_nettype none
module tb_adc_control_sequencer;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_i = 1'b0; // System clock, 100 MHz
    logic rst_i = 1'b1; // Synchronous reset, high for the first two cycles
    logic ce_i = 1'b1; // Clock enable, dropped once to check the freeze
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'hf;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic ack_o;
    logic conv_reset_o;
    logic conv_start_o;
    logic conv_power_o;
    logic conv_clk_o;
    logic [1:0] conv_channel_o;
    logic conv_done_i = 1'b0; // Completion pulse driven in place of the analog core
    logic [11:0] conv_data_i = 12'h000;
    logic [3:0] analog_en_o;
    logic [3:0] digital_en_o;
    logic test_mode_o;
    logic irq_o;
    int n_mismatch = 0; // Mismatches seen
    int n_tests = 0; // Comparisons made
    int n_rst = 0; // Converter reset pulses seen
    int n_go = 0; // Conversion start pulses seen
    logic [31:0] rd; // Last read data
    int per; // Measured converter clock period
    logic [3:0] exp_an; // Expected analog line mask
    logic lvl; // Converter clock level held while frozen

    // Clock generator
    always #5 clk_i = ~clk_i;

    // Pulses are counted at the edge that samples them, so a one-cycle pulse is never missed
    always @(posedge clk_i) begin
        if (conv_reset_o === 1'b1) n_rst++;
        if (conv_start_o === 1'b1) n_go++;
    end

    adcseq_top u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .conv_reset_o(conv_reset_o), .conv_start_o(conv_start_o),
        .conv_power_o(conv_power_o), .conv_clk_o(conv_clk_o),
        .conv_channel_o(conv_channel_o), .conv_done_i(conv_done_i),
        .conv_data_i(conv_data_i), .analog_en_o(analog_en_o),
        .digital_en_o(digital_en_o), .test_mode_o(test_mode_o), .irq_o(irq_o)
    );

    // Compare one value; unknowns never match because of case equality
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Classic single Wishbone cycle; holds the request until ack is sampled high
    task automatic wb(input logic w, input logic [5:0] idx, input logic [7:0] d,
                      input logic [3:0] s, output logic [31:0] q);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= {idx, 2'b00};
        sel_i <= s;
        dat_i <= {24'h0, d};
        // Wait for the answer however long it takes; only the watchdog ends a hang
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        // Idle cycle, then one more so registered side effects have landed
        repeat (2) @(posedge clk_i);
    endtask : wb

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        logic [31:0] q;
        wb(1'b1, idx, d, 4'hf, q);
    endtask : wr

    // Read and compare in one call
    task automatic rdc(input logic [5:0] idx, input logic [31:0] exp);
        wb(1'b0, idx, 8'h00, 4'hf, rd);
        chk(rd, exp);
    endtask : rdc

    // One-cycle completion pulse from the core side
    task automatic done(input logic [11:0] d);
        @(posedge clk_i);
        conv_done_i <= 1'b1;
        conv_data_i <= d;
        @(posedge clk_i);
        conv_done_i <= 1'b0;
        conv_data_i <= ~d; // Data no longer valid after the pulse
        repeat (2) @(posedge clk_i);
    endtask : done

    // Period in system cycles between two rising edges of the converter clock
    task automatic period(output int p);
        logic prev;
        int n;
        prev = conv_clk_o;
        n = 0;
        p = 0;
        while (n < 200 && !(prev === 1'b0 && conv_clk_o === 1'b1)) begin
            prev = conv_clk_o;
            @(posedge clk_i);
            n++;
        end
        prev = conv_clk_o;
        do begin
            @(posedge clk_i);
            p++;
            if (prev === 1'b0 && conv_clk_o === 1'b1) break;
            prev = conv_clk_o;
        end while (p < 200);
    endtask : period

    // Verdict and end of run
    task automatic conclude();
        if (n_mismatch == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : conclude

    // Watchdog: the whole sequence needs a few hundred cycles
    initial begin
        #200000;
        n_mismatch++;
        conclude();
    end

    // Main sequence
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        // Values after reset
        rdc(adcseq_pkg::CONTROL_IDX, 32'h0);
        rdc(adcseq_pkg::CLOCK_IDX, 32'h0);
        rdc(adcseq_pkg::RESULT_HIGH_IDX, 32'h0);
        chk({28'h0, digital_en_o}, 32'hf);
        chk({31'h0, conv_power_o}, 32'h0);
        chk({31'h0, conv_clk_o}, 32'h0);
        rdc(6'h3f, 32'h0); // Unmapped place reads zero
        // Every port field code: analog mask, digital inverse and power
        for (int c = 0; c < 8; c++) begin
            wr(adcseq_pkg::CONTROL_IDX, 8'(c << 3));
            exp_an = c[2] ? 4'hf : (4'h1 << c[1:0]) - 4'h1;
            chk({28'h0, analog_en_o}, {28'h0, exp_an});
            chk({28'h0, digital_en_o}, {28'h0, ~exp_an});
            chk({31'h0, conv_power_o}, {31'h0, exp_an != 4'h0});
        end
        // Channel codes zero to three
        for (int c = 0; c < 4; c++) begin
            wr(adcseq_pkg::CONTROL_IDX, 8'h20 | 8'(c));
            chk({30'h0, conv_channel_o}, c);
        end
        // Clock enable low freezes the divider, which otherwise toggles every cycle
        ce_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        lvl = conv_clk_o;
        repeat (3) @(posedge clk_i);
        chk({31'h0, conv_clk_o}, {31'h0, lvl});
        ce_i <= 1'b1;
        // Clock ratios; code 11 runs as the slowest ratio
        for (int c = 0; c < 4; c++) begin
            wr(adcseq_pkg::CLOCK_IDX, 8'(c));
            period(per);
            chk(per, c == 0 ? 2 : (c == 1 ? 8 : 32));
        end
        // Unused clock bits read zero; the test bit is left clear as software must
        wr(adcseq_pkg::CLOCK_IDX, 8'h7f);
        rdc(adcseq_pkg::CLOCK_IDX, 32'h03);
        chk({31'h0, test_mode_o}, 32'h0);
        // A write with lane 0 disabled is ignored
        wb(1'b1, adcseq_pkg::CLOCK_IDX, 8'h00, 4'he, rd);
        rdc(adcseq_pkg::CLOCK_IDX, 32'h03);
        wr(adcseq_pkg::CLOCK_IDX, 8'h00); // Back to the fastest ratio
        // A write of start low while it is already low starts nothing
        wr(adcseq_pkg::CONTROL_IDX, 8'h21);
        chk(n_go, 0);
        // Rise: converter reset pulse and pending flag; start after the port changes is the init
        wr(adcseq_pkg::CONTROL_IDX, 8'ha1);
        chk(n_rst, 1);
        rdc(adcseq_pkg::CONTROL_IDX, 32'he1);
        done(12'h123); // Completion before the fall must be ignored
        chk(n_go, 0);
        rdc(adcseq_pkg::CONTROL_IDX, 32'he1);
        rdc(adcseq_pkg::RESULT_HIGH_IDX, 32'h0);
        // Fall: conversion begins; start stays low until the flag clears
        wr(adcseq_pkg::CONTROL_IDX, 8'h21);
        chk(n_go, 1);
        chk(n_rst, 1);
        rdc(adcseq_pkg::CONTROL_IDX, 32'h61);
        rdc(adcseq_pkg::RESULT_LOW_IDX, 32'h0);
        // Completion: flag cleared, result split over two bytes, request flag set
        wr(adcseq_pkg::IRQ_MASK_IDX, 8'h00);
        done(12'habc);
        rdc(adcseq_pkg::CONTROL_IDX, 32'h21);
        rdc(adcseq_pkg::RESULT_HIGH_IDX, 32'hab);
        rdc(adcseq_pkg::RESULT_LOW_IDX, 32'hc0);
        rdc(adcseq_pkg::IRQ_STATUS_IDX, 32'h1);
        chk({31'h0, irq_o}, 32'h0);
        // Completion outside a conversion changes nothing
        done(12'h555);
        rdc(adcseq_pkg::RESULT_HIGH_IDX, 32'hab);
        // Unmask, then clear the request by writing one
        wr(adcseq_pkg::IRQ_MASK_IDX, 8'h01);
        rdc(adcseq_pkg::IRQ_MASK_IDX, 32'h1);
        chk({31'h0, irq_o}, 32'h1);
        wr(adcseq_pkg::IRQ_STATUS_IDX, 8'h01);
        chk({31'h0, irq_o}, 32'h0);
        rdc(adcseq_pkg::IRQ_STATUS_IDX, 32'h0);
        // Port field back to zero powers the converter down and stops its clock
        wr(adcseq_pkg::CONTROL_IDX, 8'h00);
        chk({31'h0, conv_power_o}, 32'h0);
        repeat (4) @(posedge clk_i);
        chk({31'h0, conv_clk_o}, 32'h0);
        conclude();
    end
endmodule : tb_adc_control_sequencer
`default_nettype wire

//--- verilog/adcseq_clkdiv.sv
// Converter clock divider driven from the system clock
`default_nettype none
module adcseq_clkdiv (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic run_i,
    input wire logic [1:0] sel_i,
    output logic conv_clk_o
);
    logic [4:0] count_r; // Cycles spent in the current half period
    logic [4:0] half_nxt; // Half period for the selected ratio
    logic clk_r; // Divided clock level

    // Half period lookup; the undefined code falls back to the slowest ratio
    always_comb begin
        unique case (sel_i)
            adcseq_pkg::CLKSEL_DIV2: half_nxt = adcseq_pkg::HALF_DIV2; // R11
            adcseq_pkg::CLKSEL_DIV8: half_nxt = adcseq_pkg::HALF_DIV8; // R11
            default: half_nxt = adcseq_pkg::HALF_DIV32; // R11
        endcase
    end

    // Counter and toggle; stopped while the converter is unpowered
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_r <= 5'h00;
            clk_r <= 1'b0;
        end else if (ce_i) begin
            if (!run_i) begin
                // Hold low so the core sees a clean first edge at power-up
                count_r <= 5'h00;
                clk_r <= 1'b0;
            end else if (count_r + 5'h01 >= half_nxt) begin
                count_r <= 5'h00;
                clk_r <= ~clk_r;
            end else begin
                count_r <= count_r + 5'h01;
            end
        end
    end

    assign conv_clk_o = clk_r;
endmodule : adcseq_clkdiv
`default_nettype wire

//--- verilog/adcseq_pkg.sv
// Package: register map, field layout and constants of the converter control sequencer
// Summary of operation
// [R1] Result split: high byte 11..4, low 3..0
// [R2] Control bits 2..0 pick analog input
// [R3] Port field sets count of analog lines
// [R4] Analog line: digital off, converter powered
// [R5] Port field zero keeps converter powered off
// [R6] Start rising: reset converter, set pending flag
// [R7] Conversion starts only after start falls
// [R8] Completion clears flag, sets interrupt request
// [R9] Software holds start low until done
// [R10] Software reinitialises after port field change
// [R11] Clock field selects divide by 2/8/32
// [R12] Test bit reserved, bits 6..2 read zero
// [R13] Results held until next completion
`default_nettype none
package adcseq_pkg;
    // Register indices; byte address is four times the index
    localparam logic [5:0] RESULT_LOW_IDX = 6'h20;
    localparam logic [5:0] RESULT_HIGH_IDX = 6'h21;
    localparam logic [5:0] CONTROL_IDX = 6'h22;
    localparam logic [5:0] CLOCK_IDX = 6'h23;
    localparam logic [5:0] IRQ_STATUS_IDX = 6'h24;
    localparam logic [5:0] IRQ_MASK_IDX = 6'h25;

    // Control register field positions
    localparam int CHAN_LSB = 0;
    localparam int PORT_LSB = 3;
    localparam int PEND_BIT = 6;
    localparam int START_BIT = 7;
    // Clock register field positions
    localparam int CLKSEL_LSB = 0;
    localparam int TEST_BIT = 7;
    // Interrupt status bit of a finished conversion
    localparam int IRQ_DONE_BIT = 0;

    // Values after reset
    localparam logic [2:0] CHAN_RST = 3'h0;
    localparam logic [2:0] PORT_RST = 3'h0;
    localparam logic [1:0] CLKSEL_RST = 2'h0;
    localparam logic [11:0] RESULT_RST = 12'h000;

    // Converter clock divider selections and half-period counts
    localparam logic [1:0] CLKSEL_DIV2 = 2'h0;
    localparam logic [1:0] CLKSEL_DIV8 = 2'h1;
    localparam logic [1:0] CLKSEL_DIV32 = 2'h2;
    localparam logic [4:0] HALF_DIV2 = 5'h01;
    localparam logic [4:0] HALF_DIV8 = 5'h04;
    localparam logic [4:0] HALF_DIV32 = 5'h10;

    // Start handshake states, Gray coded along idle, armed, converting
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_ARMED = 2'b01,
        SEQ_CONV = 2'b11
    } adcseq_state_e;
endpackage : adcseq_pkg
`default_nettype wire

//--- verilog/adcseq_result.sv
// Result holding register split into high and low bytes
`default_nettype none
module adcseq_result (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic load_i,
    input wire logic [11:0] data_i,
    output logic [7:0] high_o,
    output logic [7:0] low_o
);
    logic [11:0] result_r; // Last finished conversion

    // Load only on completion so a read never sees a half-updated value
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            result_r <= adcseq_pkg::RESULT_RST;
        end else if (ce_i && load_i) begin
            result_r <= data_i; // R13
        end
    end

    // Upper eight bits in the high byte, lower four in the top of the low byte
    assign high_o = result_r[11:4]; // R1
    assign low_o = {result_r[3:0], 4'h0}; // R1
endmodule : adcseq_result
`default_nettype wire

//--- verilog/adcseq_top.sv
// Converter control sequencer with Wishbone register slave
`default_nettype none
module adcseq_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Wishbone classic slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Analog core side
    output logic conv_reset_o,
    output logic conv_start_o,
    output logic conv_power_o,
    output logic conv_clk_o,
    output logic [1:0] conv_channel_o,
    input wire logic conv_done_i,
    input wire logic [11:0] conv_data_i,
    // Port B line control
    output logic [3:0] analog_en_o,
    output logic [3:0] digital_en_o,
    // Factory test bit and interrupt
    output logic test_mode_o,
    output logic irq_o
);
    // Register state
    logic [2:0] chan_r; // Selected analog input
    logic [2:0] port_cfg_r; // Port B analog line count
    logic pend_r; // Conversion pending flag, low when finished
    logic start_r; // Start control bit as last written
    logic [1:0] clksel_r; // Converter clock ratio
    logic test_r; // Reserved test bit, stored and driven to the test pin
    logic [0:0] irq_stat_r; // Sticky event bits
    logic [0:0] irq_mask_r; // Interrupt enables
    adcseq_pkg::adcseq_state_e state_r; // Start handshake state
    logic reset_pulse_r; // One-cycle converter reset
    logic start_pulse_r; // One-cycle conversion start
    logic ack_r; // Bus acknowledge
    logic [31:0] rdata_r; // Registered read data
    logic [7:0] res_high; // Result high byte
    logic [7:0] res_low; // Result low byte

    // Decoded bus events
    logic req; // Request present this cycle
    logic acc; // Access completes at this edge
    logic [5:0] idx; // Word index of the access
    logic wr_lane0; // Write that touches the low byte lane
    logic wr_ctrl; // Control register write
    logic wr_clk; // Clock register write
    logic wr_stat; // Status write, ones clear
    logic wr_mask; // Mask register write
    logic start_rise; // Start bit written 0 to 1
    logic start_fall; // Start bit written 1 to 0
    logic done_ev; // Core finished while converting
    logic load_res; // Capture new result

    // A request is taken at the edge where ack is still low; the write lands one
    // edge later, while ack stands, so a held request is never applied twice
    assign req = cyc_i && stb_i;
    assign acc = req && ack_r && ce_i;
    assign idx = adr_i[7:2];
    assign wr_lane0 = acc && we_i && sel_i[0];
    assign wr_ctrl = wr_lane0 && (idx == adcseq_pkg::CONTROL_IDX);
    assign wr_clk = wr_lane0 && (idx == adcseq_pkg::CLOCK_IDX);
    assign wr_stat = wr_lane0 && (idx == adcseq_pkg::IRQ_STATUS_IDX);
    assign wr_mask = wr_lane0 && (idx == adcseq_pkg::IRQ_MASK_IDX);
    assign start_rise = wr_ctrl && !start_r && dat_i[adcseq_pkg::START_BIT]; // R6
    assign start_fall = wr_ctrl && start_r && !dat_i[adcseq_pkg::START_BIT]; // R7
    // A fresh start write in the same cycle overrides the finishing conversion
    assign done_ev = ce_i && conv_done_i && (state_r == adcseq_pkg::SEQ_CONV) && !start_rise;
    assign load_res = done_ev;

    // Acknowledge one cycle after the request, drop the cycle after
    // Fixed latency keeps the slave simple; there are no wait states to track
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else if (ce_i) begin
            ack_r <= req && !ack_r;
        end
    end

    // Read mux, sampled while the request waits so data stands with ack
    // Reads have no side effects, so a repeated read is harmless
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_r <= 32'h0000_0000;
        end else if (ce_i && req && !ack_r) begin
            unique case (idx)
                adcseq_pkg::RESULT_LOW_IDX: rdata_r <= {24'h00_0000, res_low}; // R1
                adcseq_pkg::RESULT_HIGH_IDX: rdata_r <= {24'h00_0000, res_high}; // R1
                adcseq_pkg::CONTROL_IDX:
                    rdata_r <= {24'h00_0000, start_r, pend_r, port_cfg_r, chan_r};
                // Bits 6..2 of the clock register always read zero
                adcseq_pkg::CLOCK_IDX:
                    rdata_r <= {24'h00_0000, test_r, 5'h00, clksel_r}; // R12
                adcseq_pkg::IRQ_STATUS_IDX: rdata_r <= {31'h0000_0000, irq_stat_r};
                adcseq_pkg::IRQ_MASK_IDX: rdata_r <= {31'h0000_0000, irq_mask_r};
                // Unmapped words answer with zero and ignore writes
                default: rdata_r <= 32'h0000_0000;
            endcase
        end
    end

    assign ack_o = ack_r;
    assign dat_o = rdata_r;

    // Software fields of the control register; pending flag is hardware owned
    // A port field change is not policed here: software must issue a start
    // pulse afterwards, otherwise the pending flag may not match the core
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            chan_r <= adcseq_pkg::CHAN_RST;
            port_cfg_r <= adcseq_pkg::PORT_RST;
            start_r <= 1'b0;
        end else if (wr_ctrl) begin
            chan_r <= dat_i[adcseq_pkg::CHAN_LSB +: 3]; // R2
            port_cfg_r <= dat_i[adcseq_pkg::PORT_LSB +: 3]; // R3
            start_r <= dat_i[adcseq_pkg::START_BIT];
        end
    end

    // Clock register; the test bit is kept for readback and reaches a pin only
    // Software must leave the test bit clear; it has no effect inside this block
    // Bits 6..2 have no storage at all, so they cannot be written
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clksel_r <= adcseq_pkg::CLKSEL_RST;
            test_r <= 1'b0;
        end else if (wr_clk) begin
            clksel_r <= dat_i[adcseq_pkg::CLKSEL_LSB +: 2]; // R11
            test_r <= dat_i[adcseq_pkg::TEST_BIT]; // R12
        end
    end

    // Start handshake: rise arms and resets, fall launches, done retires
    // Edges come from the written bit, so a rewrite of the same value does nothing
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= adcseq_pkg::SEQ_IDLE;
        end else if (ce_i) begin
            if (start_rise) begin
                // A rise mid-conversion abandons it, which is why software waits
                state_r <= adcseq_pkg::SEQ_ARMED; // R6 R9
            end else begin
                unique case (state_r)
                    adcseq_pkg::SEQ_IDLE: begin
                        state_r <= adcseq_pkg::SEQ_IDLE;
                    end
                    adcseq_pkg::SEQ_ARMED: begin
                        if (start_fall) begin
                            state_r <= adcseq_pkg::SEQ_CONV; // R7
                        end
                    end
                    adcseq_pkg::SEQ_CONV: begin
                        if (done_ev) begin
                            state_r <= adcseq_pkg::SEQ_IDLE; // R8
                        end
                    end
                    // Code 10 is never entered; recover to idle
                    default: begin
                        state_r <= adcseq_pkg::SEQ_IDLE;
                    end
                endcase
            end
        end
    end

    // Pending flag: set by a start rise, cleared on completion
    // Reads one while a conversion is owed, zero once the result is in place
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend_r <= 1'b0;
        end else if (ce_i) begin
            if (start_rise) begin
                pend_r <= 1'b1; // R6
            end else if (done_ev) begin
                pend_r <= 1'b0; // R8
            end
        end
    end

    // Single-cycle strobes to the analog core
    // Registered so the core never sees a combinational decode of the bus
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reset_pulse_r <= 1'b0;
            start_pulse_r <= 1'b0;
        end else if (ce_i) begin
            reset_pulse_r <= start_rise; // R6
            // Only a fall that follows a rise launches a conversion
            start_pulse_r <= start_fall && (state_r == adcseq_pkg::SEQ_ARMED); // R7
        end
    end

    assign conv_reset_o = reset_pulse_r;
    assign conv_start_o = start_pulse_r;

    // Sticky interrupt status; a set in the clearing cycle wins
    // Losing a completion would hang a polling driver, hence the priority
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_r <= 1'b0;
        end else if (ce_i) begin
            if (done_ev) begin
                irq_stat_r[adcseq_pkg::IRQ_DONE_BIT] <= 1'b1; // R8
            end else if (wr_stat && dat_i[adcseq_pkg::IRQ_DONE_BIT]) begin
                irq_stat_r[adcseq_pkg::IRQ_DONE_BIT] <= 1'b0;
            end
        end
    end

    // Interrupt mask register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_mask_r <= 1'b0;
        end else if (wr_mask) begin
            irq_mask_r <= dat_i[adcseq_pkg::IRQ_DONE_BIT];
        end
    end

    // Request reaches the pin only when enabled
    assign irq_o = |(irq_stat_r & irq_mask_r); // R8

    // Port B lines counted up from line zero; top bit set takes all four
    // An analog line loses its digital enable, which is the inverse of its analog enable
    for (genvar i = 0; i < 4; i++) begin : g_port
        assign analog_en_o[i] = port_cfg_r[2] || (port_cfg_r[1:0] > 2'(i)); // R3 R4
        assign digital_en_o[i] = !analog_en_o[i]; // R4
    end

    // Converter powered whenever any line is analog
    // Power follows the registered field, so it never glitches during a write
    assign conv_power_o = |analog_en_o; // R4 R5
    // Undefined channel codes simply use the low two bits
    assign conv_channel_o = chan_r[1:0]; // R2
    assign test_mode_o = test_r;

    // Converter clock divider
    // Stops low while unpowered so the core starts from a known phase
    adcseq_clkdiv u_clkdiv (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .run_i(conv_power_o),
        .sel_i(clksel_r),
        .conv_clk_o(conv_clk_o)
    );

    // Result registers
    // Both bytes load at the completion edge, never one without the other
    adcseq_result u_result (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .load_i(load_res),
        .data_i(conv_data_i),
        .high_o(res_high),
        .low_o(res_low)
    );

    // Checks on the sequencing, paused by reset or a low clock enable
    // A frozen clock enable holds every register, so nothing is checked then
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i || !ce_i);

    a_start_reset: assert property (start_rise |=> conv_reset_o && pend_r) // R6
        else $error("Start rise did not reset converter and set flag");

    a_start_launch: assert property ( // R7
        start_fall && state_r == adcseq_pkg::SEQ_ARMED |=> conv_start_o ##1 !conv_start_o)
        else $error("Start fall after rise did not launch one conversion");

    a_launch_cause: assert property (conv_start_o |-> $past(state_r) == adcseq_pkg::SEQ_ARMED) // R7
        else $error("Conversion launched without a preceding rise");

    a_done_flags: assert property (done_ev |=> !pend_r && irq_stat_r[0]) // R8
        else $error("Completion did not clear flag and set request");

    a_result_hold: assert property (!load_res |=> $stable(res_high) && $stable(res_low)) // R13
        else $error("Result changed without a completion");

    a_result_map: assert property ( // R1
        load_res |=> res_high == $past(conv_data_i[11:4]) && res_low[7:4] == $past(conv_data_i[3:0]))
        else $error("Result bytes not split as expected");

    a_power_off: assert property (port_cfg_r == 3'h0 |-> !conv_power_o && analog_en_o == 4'h0) // R5
        else $error("Converter powered with no analog lines");

    a_port_all: assert property (port_cfg_r[2] |-> analog_en_o == 4'hf && digital_en_o == 4'h0) // R3
        else $error("Top port bit did not select all analog lines");

    a_clk_zero: assert property ( // R12
        req && !ack_r && !we_i && idx == adcseq_pkg::CLOCK_IDX |=> ack_o && dat_o[6:2] == 5'h00)
        else $error("Clock register unused bits not zero");

    // Further checks on strobes, flags, lines and results
    a_ack_once: assert property (ack_o |=> !ack_o)
        else $error("Bus acknowledge longer than one cycle");

    a_reset_only: assert property (start_rise |=> !conv_start_o) // R7
        else $error("Start rise alone launched a conversion");

    a_start_once: assert property (conv_start_o |=> !conv_start_o) // R7
        else $error("Conversion start longer than one cycle");

    a_rise_rearm: assert property (start_rise |=> state_r == adcseq_pkg::SEQ_ARMED) // R6
        else $error("Start rise did not rearm the sequencer");

    a_conv_retire: assert property (done_ev |=> state_r == adcseq_pkg::SEQ_IDLE) // R8
        else $error("Completion did not retire the conversion");

    a_pend_hold: assert property (!start_rise && !done_ev |=> $stable(pend_r)) // R8
        else $error("Pending flag moved without an event");

    a_irq_sticky: assert property (irq_stat_r[0] && !wr_stat |=> irq_stat_r[0]) // R8
        else $error("Interrupt status lost without a clear");

    a_set_wins: assert property (done_ev && wr_stat |=> irq_stat_r[0]) // R8
        else $error("Clear in the completion cycle lost the event");

    a_lines_count: assert property ( // R3
        !port_cfg_r[2] |-> analog_en_o == (4'h1 << port_cfg_r[1:0]) - 4'h1)
        else $error("Analog line count does not follow the field");

    a_power_on: assert property (port_cfg_r != 3'h0 |-> conv_power_o) // R4
        else $error("Converter unpowered with analog lines");

    a_clk_stopped: assert property (!conv_power_o |=> !conv_clk_o) // R5
        else $error("Converter clock ran while unpowered");

    a_done_ignored: assert property ( // R13
        conv_done_i && state_r != adcseq_pkg::SEQ_CONV |=> $stable(res_high) && $stable(res_low))
        else $error("Stray completion changed the result");
endmodule : adcseq_top
`default_nettype wire
